// ===== core/apm_pin_mux.sv
// Multifunction pin mux of a mono audio amplifier, with register file
//
// Contract
// RULE1: PLL reference field picks master clock, bit clock, GPIO pin or DIN.
// RULE2: PLL from DIN needs DIN function 01; from GPIO needs GPIO 0001.
// RULE3: Codec clock field picks master, bit clock, or GPIO pin (GPIO 0001).
// RULE4: Direction bit 3 set makes the device drive the bit clock pin.
// RULE5: Direction bit 2 set makes the device drive the word clock pin.
// RULE6: DIN function 01 is serial data in, 10 is general input.
// RULE7: GPIO function 0001 is clock/secondary input, 0010 general input.
// RULE8: GPIO function drives aux clock, interrupts, secondary clocks out.
// RULE9: GPIO general output needs control field 010 to place its value.
// RULE10: Serial-out pin codes give general out, aux clock, interrupts.
// RULE11: Serial-out pin codes 1000-1010 give secondary data and clocks.
// RULE12: Serial-clock pin 01 is secondary input, 10 general input.
// RULE13: Secondary bit clock input comes from GPIO pin or serial-clock pin.
// RULE14: Secondary word clock input likewise, each needing its input code.
// RULE15: Secondary data input bit picks GPIO pin or serial-clock pin.
// RULE16: Mono DAC input is left, right, or halved sum of both.
// RULE17: Software gives each exclusive function to one pin only.
// RULE18: A pin drives only under an output code; others leave it undriven.
`timescale 1ns/1ps
`default_nettype none
module apm_pin_mux
  import apm_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          reg_wr_en,
  input  wire logic [6:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output var  logic [7:0]    reg_rdata,
  input  wire logic          mclk_pin,
  input  wire logic          bclk_pin_i,
  output var  logic          bclk_pin_o,
  output var  logic          bclk_pin_oe,
  input  wire logic          wclk_pin_i,
  output var  logic          wclk_pin_o,
  output var  logic          wclk_pin_oe,
  input  wire logic          first_shared_data_in_pin,
  input  wire logic          gpio_pin_i,
  output var  logic          gpio_pin_o,
  output var  logic          gpio_pin_oe,
  input  wire logic          sclk_pin,
  output var  logic          miso_pin_o,
  output var  logic          miso_pin_oe,
  input  wire logic          prim_bclk_gen,
  input  wire logic          prim_wclk_gen,
  input  wire logic          aux_clk_gen,
  input  wire logic          first_interrupt_output_src,
  input  wire logic          second_interrupt_output_src,
  input  wire logic          sec_bclk_gen,
  input  wire logic          sec_wclk_gen,
  input  wire logic          sec_dout_gen,
  input  wire logic [DW-1:0] dac_left,
  input  wire logic [DW-1:0] dac_right,
  output var  logic [DW-1:0] dac_mono,
  output var  logic          pll_ref_clk,
  output var  logic          codec_clk,
  output var  logic          prim_bclk,
  output var  logic          prim_wclk,
  output var  logic          prim_din,
  output var  logic          sec_bclk,
  output var  logic          sec_wclk,
  output var  logic          sec_din,
  output var  logic          gpi_din,
  output var  logic          gpi_gpio,
  output var  logic          gpi_sclk
);
  typedef struct packed {
    logic [7:0]    clk_src;
    logic [7:0]    aif_dir;
    logic [7:0]    sec_src;
    logic [7:0]    gpio_fn;
    logic [7:0]    gpio_ctl;
    logic [7:0]    din_fn;
    logic [7:0]    miso_fn;
    logic [7:0]    sclk_fn;
    logic [7:0]    dac_cfg;
    logic [7:0]    rdata;
    logic          pll_ref;
    logic          codec;
    logic          pbclk;
    logic          pwclk;
    logic          pdin;
    logic          sbclk;
    logic          swclk;
    logic          sdin;
    logic          gdin;
    logic          ggpio;
    logic          gsclk;
    logic          bclk_o;
    logic          bclk_oe;
    logic          wclk_o;
    logic          wclk_oe;
    logic          gpio_o;
    logic          gpio_oe;
    logic          miso_o;
    logic          miso_oe;
    logic [DW-1:0] mono;
  } apm_state_type;

  apm_state_type s_q;
  apm_state_type s_d;
  logic [APM_NPIN-1:0] c;

  apm_sync_if #(.W(APM_NPIN)) sy ();

  apm_pin_sync #(.W(APM_NPIN)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .port     (sy)
  );

  // Pins arrive asynchronously to core_clk, so all of them are filtered
  assign sy.raw = {sclk_pin, gpio_pin_i, first_shared_data_in_pin,
                   wclk_pin_i, bclk_pin_i, mclk_pin};
  assign c = sy.clean;

  // Gate a pin level by whether its function field grants input use
  function automatic logic gate(input logic ok, input logic lvl);
    gate = ok & lvl;
  endfunction

  // Halved left-plus-right sum, one extra bit keeps the carry
  function automatic logic [DW-1:0] mix(input logic [DW-1:0] l,
                                        input logic [DW-1:0] r);
    logic signed [DW:0] sum;
    sum = $signed({l[DW-1], l}) + $signed({r[DW-1], r});
    mix = sum[DW:1];
  endfunction

  logic [1:0] pll_f;
  logic [1:0] cdc_f;
  logic [3:0] gfn;
  logic [3:0] mfn;
  logic [1:0] dfn;
  logic [1:0] sfn;
  logic       g_clkin;
  logic       s_secin;

  assign pll_f   = s_q.clk_src[APM_PLL_SRC_LSB +: 2];
  assign cdc_f   = s_q.clk_src[APM_CODEC_SRC_LSB +: 2];
  assign gfn     = s_q.gpio_fn[APM_GPIO_FN_LSB +: 4];
  assign mfn     = s_q.miso_fn[APM_MISO_FN_LSB +: 4];
  assign dfn     = s_q.din_fn[APM_DIN_FN_LSB +: 2];
  assign sfn     = s_q.sclk_fn[APM_SCLK_FN_LSB +: 2];
  assign g_clkin = (gfn == APM_GFN_CLKIN);
  assign s_secin = (sfn == APM_FN2_PRIMARY);

  always_comb begin
    s_d = s_q;
    if (reg_wr_en) begin
      case (reg_addr)
        APM_CLK_SRC_ADDR:  s_d.clk_src  = reg_wdata & APM_CLK_SRC_MASK;
        APM_AIF_DIR_ADDR:  s_d.aif_dir  = reg_wdata & APM_AIF_DIR_MASK;
        APM_SEC_SRC_ADDR:  s_d.sec_src  = reg_wdata & APM_SEC_SRC_MASK;
        APM_GPIO_FN_ADDR:  s_d.gpio_fn  = reg_wdata & APM_GPIO_FN_MASK;
        APM_GPIO_CTL_ADDR: s_d.gpio_ctl = reg_wdata & APM_GPIO_CTL_MASK;
        APM_DIN_FN_ADDR:   s_d.din_fn   = reg_wdata & APM_DIN_FN_MASK;
        APM_MISO_FN_ADDR:  s_d.miso_fn  = reg_wdata & APM_MISO_FN_MASK;
        APM_SCLK_FN_ADDR:  s_d.sclk_fn  = reg_wdata & APM_SCLK_FN_MASK;
        APM_DAC_CFG_ADDR:  s_d.dac_cfg  = reg_wdata & APM_DAC_CFG_MASK;
        default: begin
        end
      endcase
    end
    // Read data lags the address by one cycle; pin levels show in bit 0
    case (reg_addr)
      APM_CLK_SRC_ADDR:  s_d.rdata = s_q.clk_src;
      APM_AIF_DIR_ADDR:  s_d.rdata = s_q.aif_dir;
      APM_SEC_SRC_ADDR:  s_d.rdata = s_q.sec_src;
      APM_GPIO_FN_ADDR:  s_d.rdata = s_q.gpio_fn | 8'({c[APM_PIN_GPIO]});
      APM_GPIO_CTL_ADDR: s_d.rdata = s_q.gpio_ctl;
      APM_DIN_FN_ADDR:   s_d.rdata = s_q.din_fn | 8'({c[APM_PIN_DIN]});
      APM_MISO_FN_ADDR:  s_d.rdata = s_q.miso_fn;
      APM_SCLK_FN_ADDR:  s_d.rdata = s_q.sclk_fn | 8'({c[APM_PIN_SCLK]});
      APM_DAC_CFG_ADDR:  s_d.rdata = s_q.dac_cfg;
      default:           s_d.rdata = 8'h00;
    endcase

    case (pll_f)
      APM_SRC_MCLK: s_d.pll_ref = c[APM_PIN_MCLK]; // RULE1
      APM_SRC_BCLK: s_d.pll_ref = c[APM_PIN_BCLK]; // RULE1
      APM_SRC_GPIO: s_d.pll_ref = gate(g_clkin, c[APM_PIN_GPIO]); // RULE2
      default: s_d.pll_ref = gate(dfn == APM_FN2_PRIMARY,
                                  c[APM_PIN_DIN]); // RULE2
    endcase
    case (cdc_f)
      APM_SRC_MCLK: s_d.codec = c[APM_PIN_MCLK]; // RULE3
      APM_SRC_BCLK: s_d.codec = c[APM_PIN_BCLK]; // RULE3
      APM_SRC_GPIO: s_d.codec = gate(g_clkin, c[APM_PIN_GPIO]); // RULE3
      default:      s_d.codec = 1'b0;
    endcase

    // Driving the pin also feeds the own clock inward, as a master would
    s_d.bclk_oe = s_q.aif_dir[APM_BCLK_DIR_BIT]; // RULE4
    s_d.bclk_o  = s_d.bclk_oe & prim_bclk_gen; // RULE4
    s_d.pbclk   = s_d.bclk_oe ? prim_bclk_gen : c[APM_PIN_BCLK]; // RULE4
    s_d.wclk_oe = s_q.aif_dir[APM_WCLK_DIR_BIT]; // RULE5
    s_d.wclk_o  = s_d.wclk_oe & prim_wclk_gen; // RULE5
    s_d.pwclk   = s_d.wclk_oe ? prim_wclk_gen : c[APM_PIN_WCLK]; // RULE5

    s_d.pdin  = gate(dfn == APM_FN2_PRIMARY, c[APM_PIN_DIN]); // RULE6
    s_d.gdin  = gate(dfn == APM_FN2_GPI, c[APM_PIN_DIN]); // RULE6
    s_d.ggpio = gate(gfn == APM_GFN_GPI, c[APM_PIN_GPIO]); // RULE7
    s_d.gsclk = gate(sfn == APM_FN2_GPI, c[APM_PIN_SCLK]); // RULE12

    case (s_q.sec_src[APM_SBCLK_SRC_LSB +: 2])
      APM_SEC_GPIO: s_d.sbclk = gate(g_clkin, c[APM_PIN_GPIO]); // RULE13
      APM_SEC_SCLK: s_d.sbclk = gate(s_secin, c[APM_PIN_SCLK]); // RULE13
      default:      s_d.sbclk = 1'b0;
    endcase
    case (s_q.sec_src[APM_SWCLK_SRC_LSB +: 2])
      APM_SEC_GPIO: s_d.swclk = gate(g_clkin, c[APM_PIN_GPIO]); // RULE14
      APM_SEC_SCLK: s_d.swclk = gate(s_secin, c[APM_PIN_SCLK]); // RULE14
      default:      s_d.swclk = 1'b0;
    endcase
    s_d.sdin = s_q.sec_src[APM_SDIN_SRC_BIT] ?
               gate(s_secin, c[APM_PIN_SCLK]) :
               gate(g_clkin, c[APM_PIN_GPIO]); // RULE15

    // Input and unlisted codes leave the pin undriven
    s_d.gpio_oe = 1'b1;
    case (gfn)
      APM_GFN_AUX:   s_d.gpio_o = aux_clk_gen; // RULE8
      APM_GFN_FIRST_INTERRUPT_OUTPUT:  s_d.gpio_o = first_interrupt_output_src; // RULE8
      APM_GFN_SECOND_INTERRUPT_OUTPUT:  s_d.gpio_o = second_interrupt_output_src; // RULE8
      APM_GFN_SBCLK: s_d.gpio_o = sec_bclk_gen; // RULE8
      APM_GFN_SWCLK: s_d.gpio_o = sec_wclk_gen; // RULE8
      APM_GFN_GPO: begin
        s_d.gpio_oe = (s_q.gpio_ctl[APM_GPIO_CTL_LSB +: 3]
                       == APM_GCTL_GPO); // RULE9
        s_d.gpio_o  = s_d.gpio_oe & s_q.gpio_ctl[APM_GPO_VAL_BIT]; // RULE9
      end
      default: begin
        s_d.gpio_oe = 1'b0; // RULE18
        s_d.gpio_o  = 1'b0;
      end
    endcase
    s_d.miso_oe = 1'b1;
    case (mfn)
      APM_MFN_GPO:   s_d.miso_o = s_q.miso_fn[APM_GPO_VAL_BIT]; // RULE10
      APM_MFN_AUX:   s_d.miso_o = aux_clk_gen; // RULE10
      APM_MFN_FIRST_INTERRUPT_OUTPUT:  s_d.miso_o = first_interrupt_output_src; // RULE10
      APM_MFN_SECOND_INTERRUPT_OUTPUT:  s_d.miso_o = second_interrupt_output_src; // RULE10
      APM_MFN_SDOUT: s_d.miso_o = sec_dout_gen; // RULE11
      APM_MFN_SBCLK: s_d.miso_o = sec_bclk_gen; // RULE11
      APM_MFN_SWCLK: s_d.miso_o = sec_wclk_gen; // RULE11
      default: begin
        s_d.miso_oe = 1'b0; // RULE18
        s_d.miso_o  = 1'b0;
      end
    endcase

    case (s_q.dac_cfg[APM_MONO_SEL_LSB +: 2])
      APM_MONO_RIGHT: s_d.mono = dac_right; // RULE16
      APM_MONO_MIX:   s_d.mono = mix(dac_left, dac_right); // RULE16
      default:        s_d.mono = dac_left; // RULE16
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.clk_src  <= APM_CLK_SRC_RST;
      s_q.aif_dir  <= APM_AIF_DIR_RST;
      s_q.sec_src  <= APM_SEC_SRC_RST;
      s_q.gpio_fn  <= APM_GPIO_FN_RST;
      s_q.gpio_ctl <= APM_GPIO_CTL_RST;
      s_q.din_fn   <= APM_DIN_FN_RST;
      s_q.miso_fn  <= APM_MISO_FN_RST;
      s_q.sclk_fn  <= APM_SCLK_FN_RST;
      s_q.dac_cfg  <= APM_DAC_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata   = s_q.rdata;
  assign pll_ref_clk = s_q.pll_ref;
  assign codec_clk   = s_q.codec;
  assign prim_bclk   = s_q.pbclk;
  assign prim_wclk   = s_q.pwclk;
  assign prim_din    = s_q.pdin;
  assign sec_bclk    = s_q.sbclk;
  assign sec_wclk    = s_q.swclk;
  assign sec_din     = s_q.sdin;
  assign gpi_din     = s_q.gdin;
  assign gpi_gpio    = s_q.ggpio;
  assign gpi_sclk    = s_q.gsclk;
  assign bclk_pin_o  = s_q.bclk_o;
  assign bclk_pin_oe = s_q.bclk_oe;
  assign wclk_pin_o  = s_q.wclk_o;
  assign wclk_pin_oe = s_q.wclk_oe;
  assign gpio_pin_o  = s_q.gpio_o;
  assign gpio_pin_oe = s_q.gpio_oe;
  assign miso_pin_o  = s_q.miso_o;
  assign miso_pin_oe = s_q.miso_oe;
  assign dac_mono    = s_q.mono;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_pll_mclk;
    pll_f == APM_SRC_MCLK |=> pll_ref_clk == $past(c[APM_PIN_MCLK]);
  endproperty
  a_pll_mclk: assert property (p_pll_mclk) // RULE1
    else $error("PLL reference not following master clock");

  property p_pll_din_gate;
    (pll_f == APM_SRC_DIN && dfn != APM_FN2_PRIMARY) |=> !pll_ref_clk;
  endproperty
  a_pll_din_gate: assert property (p_pll_din_gate) // RULE2
    else $error("PLL fed from data-in pin without its function");

  property p_codec_gpio;
    cdc_f == APM_SRC_GPIO |=>
      codec_clk == ($past(g_clkin) & $past(c[APM_PIN_GPIO]));
  endproperty
  a_codec_gpio: assert property (p_codec_gpio) // RULE3
    else $error("Codec clock from GPIO pin mis-gated");

  property p_bclk_dir;
    ##1 bclk_pin_oe == $past(s_q.aif_dir[APM_BCLK_DIR_BIT]);
  endproperty
  a_bclk_dir: assert property (p_bclk_dir) // RULE4
    else $error("Bit clock drive does not follow direction bit");

  property p_wclk_in;
    !s_q.aif_dir[APM_WCLK_DIR_BIT] [*2] |->
      !wclk_pin_oe && prim_wclk == $past(c[APM_PIN_WCLK]);
  endproperty
  a_wclk_in: assert property (p_wclk_in) // RULE5
    else $error("Word clock not taken from pin as input");

  property p_din_gpi;
    dfn == APM_FN2_GPI |=> gpi_din == $past(c[APM_PIN_DIN]) && !prim_din;
  endproperty
  a_din_gpi: assert property (p_din_gpi) // RULE6
    else $error("Data-in pin general input wrong");

  property p_gpio_first_interrupt_output;
    gfn == APM_GFN_FIRST_INTERRUPT_OUTPUT |=>
      gpio_pin_oe && gpio_pin_o == $past(first_interrupt_output_src);
  endproperty
  a_gpio_first_interrupt_output: assert property (p_gpio_first_interrupt_output) // RULE8
    else $error("GPIO pin not carrying first interrupt");

  property p_gpo_ctl;
    (gfn == APM_GFN_GPO &&
     s_q.gpio_ctl[APM_GPIO_CTL_LSB +: 3] != APM_GCTL_GPO) |=> !gpio_pin_oe;
  endproperty
  a_gpo_ctl: assert property (p_gpo_ctl) // RULE9
    else $error("GPIO output driven without control code");

  property p_miso_sdout;
    mfn == APM_MFN_SDOUT |=> miso_pin_oe && miso_pin_o == $past(sec_dout_gen);
  endproperty
  a_miso_sdout: assert property (p_miso_sdout) // RULE11
    else $error("Serial-out pin not carrying secondary data");

  property p_sec_din;
    (s_q.sec_src[APM_SDIN_SRC_BIT] && s_secin) |=>
      sec_din == $past(c[APM_PIN_SCLK]);
  endproperty
  a_sec_din: assert property (p_sec_din) // RULE15
    else $error("Secondary data not from serial-clock pin");

  property p_mono_mix;
    s_q.dac_cfg[APM_MONO_SEL_LSB +: 2] == APM_MONO_MIX |=>
      dac_mono == mix($past(dac_left), $past(dac_right));
  endproperty
  a_mono_mix: assert property (p_mono_mix) // RULE16
    else $error("Mono input not halved sum");

  property p_undriven;
    (gfn == APM_GFN_CLKIN || gfn == APM_GFN_GPI) |=> !gpio_pin_oe;
  endproperty
  a_undriven: assert property (p_undriven) // RULE18
    else $error("GPIO pin driven under input function");

  c_bclk_master: cover property (s_q.aif_dir[APM_BCLK_DIR_BIT] ##1
                                 bclk_pin_oe);
  c_pll_din: cover property (pll_f == APM_SRC_DIN ##1 pll_ref_clk);
  c_miso_second_interrupt_output: cover property (mfn == APM_MFN_SECOND_INTERRUPT_OUTPUT ##1 miso_pin_o);
  c_sec_sclk: cover property (s_secin ##1 sec_bclk);
endmodule
`default_nettype wire

// ===== core/apm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module apm_pin_sync #(
  parameter int W = 6
) (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  apm_sync_if.sync_side port
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } apm_sync_state_type;

  apm_sync_state_type s_q;
  apm_sync_state_type s_d;

  // Stage one feeds stage two only; a level counts once two and three agree
  always_comb begin
    s_d    = s_q;
    s_d.s1 = port.raw;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.clean[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.clean = s_q.clean;
endmodule
`default_nettype wire

// ===== shared/apm_pkg.sv
// Package for the multifunction pin mux: offsets, fields, codes, resets
package apm_pkg;

  // Register offsets on the control port
  localparam logic [6:0] APM_CLK_SRC_ADDR  = 7'h04;
  localparam logic [6:0] APM_AIF_DIR_ADDR  = 7'h1b;
  localparam logic [6:0] APM_SEC_SRC_ADDR  = 7'h1f;
  localparam logic [6:0] APM_GPIO_FN_ADDR  = 7'h34;
  localparam logic [6:0] APM_GPIO_CTL_ADDR = 7'h35;
  localparam logic [6:0] APM_DIN_FN_ADDR   = 7'h36;
  localparam logic [6:0] APM_MISO_FN_ADDR  = 7'h37;
  localparam logic [6:0] APM_SCLK_FN_ADDR  = 7'h38;
  localparam logic [6:0] APM_DAC_CFG_ADDR  = 7'h3f;

  // Writable bits of each register; the rest read as zero, but bit 0 of GPIO, data-in and serial-clock function reads the pin
  localparam logic [7:0] APM_CLK_SRC_MASK  = 8'h0f;
  localparam logic [7:0] APM_AIF_DIR_MASK  = 8'h0c;
  localparam logic [7:0] APM_SEC_SRC_MASK  = 8'h79;
  localparam logic [7:0] APM_GPIO_FN_MASK  = 8'h3c;
  localparam logic [7:0] APM_GPIO_CTL_MASK = 8'h0f;
  localparam logic [7:0] APM_DIN_FN_MASK   = 8'h06;
  localparam logic [7:0] APM_MISO_FN_MASK  = 8'h1f;
  localparam logic [7:0] APM_SCLK_FN_MASK  = 8'h06;
  localparam logic [7:0] APM_DAC_CFG_MASK  = 8'h30;

  // Reset values
  localparam logic [7:0] APM_CLK_SRC_RST  = 8'h00;
  localparam logic [7:0] APM_AIF_DIR_RST  = 8'h00;
  localparam logic [7:0] APM_SEC_SRC_RST  = 8'h00;
  localparam logic [7:0] APM_GPIO_FN_RST  = 8'h00;
  localparam logic [7:0] APM_GPIO_CTL_RST = 8'h00;
  localparam logic [7:0] APM_DIN_FN_RST   = 8'h00;
  localparam logic [7:0] APM_MISO_FN_RST  = 8'h00;
  localparam logic [7:0] APM_SCLK_FN_RST  = 8'h00;
  localparam logic [7:0] APM_DAC_CFG_RST  = 8'h00;

  // Field positions (least significant bit)
  localparam int APM_PLL_SRC_LSB   = 2;
  localparam int APM_CODEC_SRC_LSB = 0;
  localparam int APM_BCLK_DIR_BIT  = 3;
  localparam int APM_WCLK_DIR_BIT  = 2;
  localparam int APM_SBCLK_SRC_LSB = 5;
  localparam int APM_SWCLK_SRC_LSB = 3;
  localparam int APM_SDIN_SRC_BIT  = 0;
  localparam int APM_GPIO_FN_LSB   = 2;
  localparam int APM_GPIO_CTL_LSB  = 1;
  localparam int APM_GPO_VAL_BIT   = 0;
  localparam int APM_DIN_FN_LSB    = 1;
  localparam int APM_MISO_FN_LSB   = 1;
  localparam int APM_SCLK_FN_LSB   = 1;
  localparam int APM_PIN_STAT_BIT  = 0;
  localparam int APM_MONO_SEL_LSB  = 4;

  // Two-bit clock source codes
  localparam logic [1:0] APM_SRC_MCLK = 2'h0;
  localparam logic [1:0] APM_SRC_BCLK = 2'h1;
  localparam logic [1:0] APM_SRC_GPIO = 2'h2;
  localparam logic [1:0] APM_SRC_DIN  = 2'h3;
  // Secondary input sources
  localparam logic [1:0] APM_SEC_GPIO = 2'h0;
  localparam logic [1:0] APM_SEC_SCLK = 2'h1;
  // Two-bit pin function codes (data-in and serial-clock pins)
  localparam logic [1:0] APM_FN2_PRIMARY = 2'h1;
  localparam logic [1:0] APM_FN2_GPI     = 2'h2;
  // General-purpose/data-out pin codes
  localparam logic [3:0] APM_GFN_CLKIN = 4'h1;
  localparam logic [3:0] APM_GFN_GPI   = 4'h2;
  localparam logic [3:0] APM_GFN_GPO   = 4'h3;
  localparam logic [3:0] APM_GFN_AUX   = 4'h4;
  localparam logic [3:0] APM_GFN_FIRST_INTERRUPT_OUTPUT  = 4'h5;
  localparam logic [3:0] APM_GFN_SECOND_INTERRUPT_OUTPUT  = 4'h6;
  localparam logic [3:0] APM_GFN_SBCLK = 4'h8;
  localparam logic [3:0] APM_GFN_SWCLK = 4'h9;
  localparam logic [2:0] APM_GCTL_GPO  = 3'h2;
  // Serial-out control pin codes
  localparam logic [3:0] APM_MFN_GPO   = 4'h2;
  localparam logic [3:0] APM_MFN_AUX   = 4'h3;
  localparam logic [3:0] APM_MFN_FIRST_INTERRUPT_OUTPUT  = 4'h4;
  localparam logic [3:0] APM_MFN_SECOND_INTERRUPT_OUTPUT  = 4'h5;
  localparam logic [3:0] APM_MFN_SDOUT = 4'h8;
  localparam logic [3:0] APM_MFN_SBCLK = 4'h9;
  localparam logic [3:0] APM_MFN_SWCLK = 4'ha;
  // Mono DAC input select
  localparam logic [1:0] APM_MONO_LEFT  = 2'h0;
  localparam logic [1:0] APM_MONO_RIGHT = 2'h1;
  localparam logic [1:0] APM_MONO_MIX   = 2'h2;

  // Bit positions of the synchronised pin vector
  localparam int APM_NPIN     = 6;
  localparam int APM_PIN_MCLK = 0;
  localparam int APM_PIN_BCLK = 1;
  localparam int APM_PIN_WCLK = 2;
  localparam int APM_PIN_DIN  = 3;
  localparam int APM_PIN_GPIO = 4;
  localparam int APM_PIN_SCLK = 5;

endpackage

// ===== shared/apm_sync_if.sv
// Interface carrying raw pin levels in and filtered levels out
`timescale 1ns/1ps
`default_nettype none
interface apm_sync_if #(parameter int W = 6);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface
`default_nettype wire

// ===== sim/apm_host_model.sv
// Host side model: drives pin levels, yields pins the device takes
`timescale 1ns/1ps
`default_nettype none
module apm_host_model (
  input  wire logic [5:0] lvl,
  input  wire logic [3:0] dev_o,
  input  wire logic [3:0] dev_oe,
  output var  logic [5:0] pin
);
  // Host stops driving a shared pin once the device owns it
  always_comb begin
    pin = lvl;
    if (dev_oe[0]) pin[1] = dev_o[0];
    if (dev_oe[1]) pin[2] = dev_o[1];
    if (dev_oe[2]) pin[4] = dev_o[2];
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the multifunction pin mux
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apm_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rd;
  logic [5:0]  lvl = 6'h00;
  logic [5:0]  pin;
  logic [7:0]  src = 8'h00;
  logic [15:0] dl = 16'h0000;
  logic [15:0] dr = 16'h0000;
  logic [15:0] mono;
  logic [10:0] rt;
  logic [10:0] xr;
  logic [7:0]  xp;
  logic        st;
  logic [3:0]  po;
  logic [3:0]  oe;
  logic [7:0]  r [9];
  int          err_total = 0;
  int          checked = 0;
  logic [6:0]  ad [9] = '{APM_CLK_SRC_ADDR, APM_AIF_DIR_ADDR,
    APM_SEC_SRC_ADDR, APM_GPIO_FN_ADDR, APM_GPIO_CTL_ADDR, APM_DIN_FN_ADDR,
    APM_MISO_FN_ADDR, APM_SCLK_FN_ADDR, APM_DAC_CFG_ADDR};
  logic [7:0]  mk [9] = '{APM_CLK_SRC_MASK, APM_AIF_DIR_MASK,
    APM_SEC_SRC_MASK, APM_GPIO_FN_MASK, APM_GPIO_CTL_MASK, APM_DIN_FN_MASK,
    APM_MISO_FN_MASK, APM_SCLK_FN_MASK, APM_DAC_CFG_MASK};

  always #2.5 core_clk = ~core_clk;

  apm_host_model host_u (.lvl(lvl), .dev_o(po), .dev_oe(oe), .pin(pin));

  apm_pin_mux dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(wr), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rd), .mclk_pin(pin[0]),
    .bclk_pin_i(pin[1]), .bclk_pin_o(po[0]), .bclk_pin_oe(oe[0]),
    .wclk_pin_i(pin[2]), .wclk_pin_o(po[1]), .wclk_pin_oe(oe[1]),
    .first_shared_data_in_pin(pin[3]), .gpio_pin_i(pin[4]),
    .gpio_pin_o(po[2]), .gpio_pin_oe(oe[2]), .sclk_pin(pin[5]),
    .miso_pin_o(po[3]), .miso_pin_oe(oe[3]), .prim_bclk_gen(src[0]),
    .prim_wclk_gen(src[1]), .aux_clk_gen(src[2]),
    .first_interrupt_output_src(src[3]),
    .second_interrupt_output_src(src[4]), .sec_bclk_gen(src[5]),
    .sec_wclk_gen(src[6]), .sec_dout_gen(src[7]), .dac_left(dl),
    .dac_right(dr), .dac_mono(mono), .pll_ref_clk(rt[10]),
    .codec_clk(rt[9]), .prim_bclk(rt[8]), .prim_wclk(rt[7]),
    .prim_din(rt[6]), .sec_bclk(rt[5]), .sec_wclk(rt[4]), .sec_din(rt[3]),
    .gpi_din(rt[2]), .gpi_gpio(rt[1]), .gpi_sclk(rt[0]));

  function automatic logic clk_x(logic [1:0] s, logic dok, logic g1);
    case (s)
      2'h0: return lvl[0];
      2'h1: return lvl[1];
      2'h2: return g1;
      default: return dok & lvl[3];
    endcase
  endfunction

  function automatic logic sec_x(logic [1:0] s, logic g1, logic s1);
    return (s == 2'h0) ? g1 : (s == 2'h1) ? s1 : 1'b0;
  endfunction

  function automatic logic [10:0] route_x();
    logic g1;
    logic s1;
    logic dn;
    g1 = (r[3][5:2] == 4'h1) & lvl[4];
    s1 = (r[7][2:1] == 2'h1) & lvl[5];
    dn = r[5][2:1] == 2'h1;
    return {clk_x(r[0][3:2], dn, g1), clk_x(r[0][1:0], 1'b0, g1),
      r[1][3] ? src[0] : lvl[1], r[1][2] ? src[1] : lvl[2], dn & lvl[3],
      sec_x(r[2][6:5], g1, s1), sec_x(r[2][4:3], g1, s1),
      r[2][0] ? s1 : g1, (r[5][2:1] == 2'h2) & lvl[3],
      (r[3][5:2] == 4'h2) & lvl[4], (r[7][2:1] == 2'h2) & lvl[5]};
  endfunction

  // Drive pair {enable, value} per output code; other codes float
  function automatic logic [7:0] pin_x();
    logic [1:0] g;
    logic [1:0] m;
    case (r[3][5:2])
      4'h3: g = {r[4][3:1] == 3'h2, r[4][0]};
      4'h4: g = {1'b1, src[2]};
      4'h5: g = {1'b1, src[3]};
      4'h6: g = {1'b1, src[4]};
      4'h8: g = {1'b1, src[5]};
      4'h9: g = {1'b1, src[6]};
      default: g = 2'h0;
    endcase
    case (r[6][4:1])
      4'h2: m = {1'b1, r[6][0]};
      4'h3: m = {1'b1, src[2]};
      4'h4: m = {1'b1, src[3]};
      4'h5: m = {1'b1, src[4]};
      4'h8: m = {1'b1, src[7]};
      4'h9: m = {1'b1, src[5]};
      4'ha: m = {1'b1, src[6]};
      default: m = 2'h0;
    endcase
    return {m[1], g[1], r[1][2], r[1][3], &m, &g, src[1] & r[1][2],
      src[0] & r[1][3]};
  endfunction

  function automatic logic [15:0] mono_x();
    logic [16:0] s;
    s = {dl[15], dl} + {dr[15], dr};
    case (r[8][5:4])
      2'h1: return dr;
      2'h2: return s[16:1];
      default: return dl;
    endcase
  endfunction

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(logic [6:0] a, logic [7:0] d);
    @(posedge core_clk);
    #1;
    wr = 1'b1;
    addr = a;
    wd = d;
  endtask

  task automatic rd_chk(logic [6:0] a, logic [7:0] e);
    @(posedge core_clk);
    #1;
    wr = 1'b0;
    addr = a;
    @(posedge core_clk);
    #1;
    chk("reg_rdata", 16'(rd), 16'(e));
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(36584));
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(ad[i], 8'h00);
    wr_reg(7'h7f, 8'hff);
    rd_chk(7'h7f, 8'h00);
    for (int it = 0; it < 240; it++) begin
      for (int i = 0; i < 9; i++) r[i] = 8'($urandom());
      // First passes walk every code of the wide fields
      if (it < 16) begin
        r[0][3:0] = it[3:0];
        r[3][5:2] = it[3:0];
        r[6][4:1] = it[3:0];
        r[4][3:1] = it[0] ? 3'h2 : 3'h5;
      end
      // Bit clock pin stays an input while it feeds a clock
      if (r[0][3:2] == 2'h1 || r[0][1:0] == 2'h1) r[1][3] = 1'b0;
      for (int i = 0; i < 9; i++) begin
        wr_reg(ad[i], r[i]);
        r[i] = r[i] & mk[i];
      end
      lvl = 6'($urandom());
      src = 8'($urandom());
      dl = 16'($urandom());
      dr = 16'($urandom());
      @(posedge core_clk);
      #1;
      wr = 1'b0;
      // Pins need five edges to reach the routed outputs
      repeat (6) @(posedge core_clk);
      #1;
      xr = route_x();
      xp = pin_x();
      chk("clk_src", 16'(rt[10:9]), 16'(xr[10:9]));
      chk("prim_clk", 16'(rt[8:7]), 16'(xr[8:7]));
      chk("din", 16'({rt[6], rt[2]}), 16'({xr[6], xr[2]}));
      chk("sec_in", 16'(rt[5:3]), 16'(xr[5:3]));
      chk("gpi", 16'(rt[1:0]), 16'(xr[1:0]));
      chk("pin_oe", 16'(oe), 16'(xp[7:4]));
      chk("pin_o", 16'(po & oe), 16'(xp[3:0]));
      chk("dac_mono", mono, mono_x());
      // Read back once pins settled; bit 0 of three registers is pin status
      case (it % 9)
        3: st = xp[6] ? xp[2] : lvl[4];
        5: st = lvl[3];
        7: st = lvl[5];
        default: st = 1'b0;
      endcase
      rd_chk(ad[it % 9], r[it % 9] | 8'(st));
    end
    test_done();
  end

  // Run needs about 4300 cycles; allow several times that
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
